// file: hdl/crc_ctrl.sv
/*
 * crc_ctrl: conversion scheduling, one-shot trigger, read-only ID
 * registers and fan pwm period/duty generator.
 * Assumes the serial front end presents one-cycle read/write requests
 * synchronous to i_clock and the measurement datapath pulses
 * i_conv_done when a started conversion cycle completes.
 */
`timescale 1ns/100ps

module crc_ctrl
    import crc_pkg::*;
#(
    parameter int unsigned SLOW_PERIOD_CYCLES = CRC_SLOW_PERIOD_CYC
) (
    // clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_resetn,
    // register request and read data
    input  wire crc_reg_req_t i_reg_req,
    output logic [7:0]        o_reg_rdata,
    output logic              o_reg_rvalid,
    // mode and measurement datapath
    input  wire logic         i_standby,
    input  wire logic         i_conv_done,
    output logic              o_conv_start,
    output logic              o_conv_busy,
    output logic [7:0]        o_rate_code,
    // fan pwm
    input  wire crc_pwm_cfg_t i_pwm_cfg,
    input  wire logic         i_pwm_tick,
    output logic              o_pwm_level
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] conv_period(input logic [7:0] code);
        logic [7:0] eff;
        eff = (code > CRC_RATE_MAX_CODE) ? CRC_RATE_MAX_CODE : code;
        conv_period = 32'(SLOW_PERIOD_CYCLES) >> eff;
    endfunction

    function automatic logic [5:0] pwm_full(input logic [4:0] freq);
        logic [4:0] f;
        f = (freq == CRC_PWM_FREQ_ZERO) ? CRC_PWM_FREQ_MIN : freq;
        pwm_full = {f, 1'b0};
    endfunction

    function automatic logic addr_hit(input crc_reg_req_t req, input logic [7:0] addr);
        addr_hit = (req.addr == addr);
    endfunction

    // ------------------------------------------------------------
    // registers and read path
    // ------------------------------------------------------------
    logic [7:0] rate_r;
    logic [7:0] rate_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       rvalid_nxt;
    logic       oneshot_wr;

    always_comb begin
        rate_nxt   = rate_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = i_reg_req.rd;
        oneshot_wr = 1'b0;
        if (i_reg_req.wr) begin
            if (addr_hit(i_reg_req, CRC_ADDR_RATE)) begin
                rate_nxt = i_reg_req.wdata;
            end else if (i_reg_req.addr == CRC_ADDR_ONESHOT) begin
                oneshot_wr = 1'b1;
            end
        end
        if (i_reg_req.rd) begin
            if (addr_hit(i_reg_req, CRC_ADDR_RATE)) begin
                rdata_nxt = rate_r;
            end else if (i_reg_req.addr == CRC_ADDR_MAKER_ID) begin
                rdata_nxt = CRC_MAKER_ID_VAL;
            end else if (i_reg_req.addr == CRC_ADDR_DIE_REV) begin
                rdata_nxt = CRC_DIE_REV_VAL;
            end else begin
                rdata_nxt = CRC_READ_ZERO;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rate_r   <= CRC_RATE_RESET;
            rdata_r  <= CRC_READ_ZERO;
            rvalid_r <= 1'b0;
        end else begin
            rate_r   <= rate_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // ------------------------------------------------------------
    // conversion scheduler
    // ------------------------------------------------------------
    crc_conv_state_t state_r;
    crc_conv_state_t state_nxt;
    logic [31:0]     timer_r;
    logic [31:0]     timer_nxt;
    logic            due_r;
    logic            due_nxt;
    logic            shot_r;
    logic            shot_nxt;
    logic            start_r;
    logic            start_nxt;
    logic [31:0]     period;

    assign period = conv_period(rate_r);

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r + 32'h0000_0001;
        due_nxt   = due_r;
        shot_nxt  = shot_r;
        start_nxt = 1'b0;
        // start decision consumes pending events
        case (state_r)
            CRC_CONV_IDLE: begin
                if (due_r || shot_r) begin
                    start_nxt = 1'b1;
                    due_nxt   = 1'b0;
                    shot_nxt  = 1'b0;
                    state_nxt = CRC_CONV_BUSY;
                end
            end
            CRC_CONV_BUSY: begin
                if (i_conv_done) begin
                    state_nxt = CRC_CONV_IDLE;
                end
            end
            default: begin
                state_nxt = CRC_CONV_IDLE;
            end
        endcase
        // new events win over a clear in the same cycle
        if (i_standby) begin
            timer_nxt = 32'h0000_0000;
            due_nxt   = 1'b0;
            if (oneshot_wr) begin
                shot_nxt = 1'b1;
            end
        end else begin
            shot_nxt = 1'b0;
            if (timer_r >= period - 32'h0000_0001) begin
                timer_nxt = 32'h0000_0000;
                due_nxt   = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= CRC_CONV_IDLE;
            timer_r <= 32'h0000_0000;
            due_r   <= 1'b0;
            shot_r  <= 1'b0;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            due_r   <= due_nxt;
            shot_r  <= shot_nxt;
            start_r <= start_nxt;
        end
    end

    // ------------------------------------------------------------
    // fan pwm
    // ------------------------------------------------------------
    logic [5:0] pwm_cnt_r;
    logic [5:0] pwm_cnt_nxt;
    logic       pwm_lvl_r;
    logic       pwm_lvl_nxt;

    always_comb begin
        pwm_cnt_nxt = pwm_cnt_r;
        if (i_pwm_tick) begin
            if (pwm_cnt_r >= pwm_full(i_pwm_cfg.freq) - CRC_PWM_CNT_ONE) begin
                pwm_cnt_nxt = CRC_PWM_CNT_ZERO;
            end else begin
                pwm_cnt_nxt = pwm_cnt_r + CRC_PWM_CNT_ONE;
            end
        end
        pwm_lvl_nxt = (pwm_cnt_nxt < i_pwm_cfg.duty);
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            pwm_cnt_r <= CRC_PWM_CNT_ZERO;
            pwm_lvl_r <= 1'b0;
        end else begin
            pwm_cnt_r <= pwm_cnt_nxt;
            pwm_lvl_r <= pwm_lvl_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_reg_rdata  = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_conv_start = start_r;
    assign o_conv_busy  = (state_r == CRC_CONV_BUSY);
    assign o_rate_code  = rate_r;
    assign o_pwm_level  = pwm_lvl_r;

endmodule

// file: hdl/crc_pkg.sv
/*
 * crc_pkg: constants, register map and carrier types for the
 * conversion-rate / one-shot / identification register block.
 * Assumes a register-level front end (serial slave) that delivers
 * single-cycle read and write requests on the device clock.
 */
package crc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CRC_ADDR_RATE     = 8'h04;
    localparam logic [7:0] CRC_ADDR_ONESHOT  = 8'h0F;
    localparam logic [7:0] CRC_ADDR_MAKER_ID = 8'hFE;
    localparam logic [7:0] CRC_ADDR_DIE_REV  = 8'hFF;

    localparam logic [7:0] CRC_RATE_RESET    = 8'h08;
    localparam logic [7:0] CRC_RATE_MAX_CODE = 8'h09;
    localparam logic [7:0] CRC_READ_ZERO     = 8'h00;

    // identification values: arbitrary neutral codes
    localparam logic [7:0] CRC_MAKER_ID_VAL  = 8'h5A;
    localparam logic [7:0] CRC_DIE_REV_VAL   = 8'hA5;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CRC_CLK_HZ          = 100_000_000;
    localparam int unsigned CRC_SLOW_PERIOD_S   = 16;  // 0.0625 Hz
    localparam int unsigned CRC_SLOW_PERIOD_CYC = CRC_SLOW_PERIOD_S * CRC_CLK_HZ;

    // ------------------------------------------------------------
    // pwm
    // ------------------------------------------------------------
    localparam logic [4:0] CRC_PWM_FREQ_ZERO = 5'h00;
    localparam logic [4:0] CRC_PWM_FREQ_MIN  = 5'h01;
    localparam logic [5:0] CRC_PWM_CNT_ZERO  = 6'h00;
    localparam logic [5:0] CRC_PWM_CNT_ONE   = 6'h01;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crc_reg_req_t;

    typedef struct packed {
        logic [4:0] freq;
        logic [5:0] duty;
    } crc_pwm_cfg_t;

    typedef enum logic [0:0] {
        CRC_CONV_IDLE = 1'b0,
        CRC_CONV_BUSY = 1'b1
    } crc_conv_state_t;

endpackage

// file: tb/crc_ctrl_properties.sv
/* port checker for crc_ctrl
   bound to every crc_ctrl instance */
`timescale 1ns/100ps
module crc_ctrl_properties
    import crc_pkg::*;
(
    // watched ports
    input wire logic         i_clock,
    input wire logic         i_resetn,
    input wire crc_reg_req_t i_reg_req,
    input wire logic [7:0]   o_reg_rdata,
    input wire logic         o_reg_rvalid,
    input wire logic         i_standby,
    input wire logic         o_conv_start,
    input wire logic         o_conv_busy,
    input wire logic [7:0]   o_rate_code,
    input wire crc_pwm_cfg_t i_pwm_cfg,
    input wire logic         o_pwm_level
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // ----
    // assertions
    // ----
    rd_answer_a: assert property (i_reg_req.rd |=> o_reg_rvalid)
        else $error("read not answered");
    rd_only_a: assert property (!i_reg_req.rd |=> !o_reg_rvalid)
        else $error("stray read valid");
    die_rev_a: assert property (i_reg_req.rd && i_reg_req.addr == CRC_ADDR_DIE_REV
        |=> o_reg_rdata == CRC_DIE_REV_VAL) else $error("revision code wrong");
    rate_load_a: assert property (i_reg_req.wr && i_reg_req.addr == CRC_ADDR_RATE
        |=> o_rate_code == $past(i_reg_req.wdata)) else $error("rate not loaded");
    rate_hold_a: assert property (!(i_reg_req.wr && i_reg_req.addr == CRC_ADDR_RATE)
        |=> $stable(o_rate_code)) else $error("rate changed unasked");
    shot_start_a: assert property ((i_standby && i_reg_req.wr
        && i_reg_req.addr == CRC_ADDR_ONESHOT && !o_conv_busy && !o_conv_start)
        ##1 (i_standby && !o_conv_start) |=> o_conv_start) else $error("one-shot lost");
    start_once_a: assert property (o_conv_start |=> !o_conv_start && o_conv_busy)
        else $error("start not single");
    busy_quiet_a: assert property (o_conv_start |-> o_conv_busy && !$past(o_conv_busy))
        else $error("start while busy");
    pwm_off_a: assert property (i_pwm_cfg.duty == 6'h00 |=> !o_pwm_level)
        else $error("zero duty drives high");
    pwm_full_a: assert property (i_pwm_cfg.duty >= 6'h3E |=> o_pwm_level)
        else $error("full duty drops low");
    cover property (o_conv_start ##1 o_conv_busy ##[1:20] !o_conv_busy);
    cover property (i_reg_req.rd && i_reg_req.addr == CRC_ADDR_DIE_REV);
    cover property (o_pwm_level ##1 !o_pwm_level);
endmodule
bind crc_ctrl crc_ctrl_properties chk_u (.i_clock, .i_resetn, .i_reg_req, .o_reg_rdata,
    .o_reg_rvalid, .i_standby, .o_conv_start, .o_conv_busy, .o_rate_code, .i_pwm_cfg,
    .o_pwm_level);

// file: tb/crc_datapath_model.sv
/* conversion datapath stand-in
   ends each started conversion after a short or long delay */
`timescale 1ns/100ps
module crc_datapath_model (
    // clock, reset, control
    input  wire logic i_clock,
    input  wire logic i_resetn,
    input  wire logic i_start,
    input  wire logic i_slow,
    // completion pulse
    output logic      o_done
);
    int cnt;
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= 0;
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt == 1);
            cnt <= i_start ? (i_slow ? 9 : 2) : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule

// file: tb/crc_ctrl_tb.sv
/* self-checking bench for crc_ctrl
   crc_datapath_model ends conversions */
`timescale 1ns/100ps
module crc_ctrl_tb;
    import crc_pkg::*;
    logic         i_clock = 0, i_resetn = 0, i_standby = 1, i_slow = 0, i_pwm_tick = 1;
    crc_reg_req_t i_reg_req = '0;
    crc_pwm_cfg_t i_pwm_cfg = '0;
    logic         i_conv_done, o_reg_rvalid, o_conv_start, o_conv_busy, o_pwm_level;
    logic [7:0]   o_reg_rdata, o_rate_code;
    logic [7:0]   codes[7] = '{8'h00, 8'h05, 8'h08, 8'h09, 8'h0A, 8'hFF, 8'h03};
    logic [15:0]  n, s0, starts = 0;
    int           bad_count = 0, check_count = 0, seed = 69499;
    crc_ctrl #(.SLOW_PERIOD_CYCLES(4096)) dut_u (.i_clock, .i_resetn, .i_reg_req, .o_reg_rdata,
        .o_reg_rvalid, .i_standby, .i_conv_done, .o_conv_start, .o_conv_busy, .o_rate_code,
        .i_pwm_cfg, .i_pwm_tick, .o_pwm_level);
    crc_datapath_model dp_u (.i_clock, .i_resetn, .i_start(o_conv_start), .i_slow,
        .o_done(i_conv_done));
    initial forever #5 i_clock = ~i_clock;
    always @(posedge i_clock) starts <= starts + 16'(o_conv_start);
    function automatic logic [15:0] exp_per(input logic [7:0] c);
        return 16'(4096 >> ((c > 8'h09) ? 9 : c));
    endfunction
    function automatic logic [15:0] exp_hi(input logic [4:0] f, input logic [5:0] d);
        logic [6:0] full;
        full = (f == 5'h00) ? 7'h02 : {1'b0, f, 1'b0};
        return (7'(d) < full) ? 16'(d) : 16'(full);
    endfunction
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock) #1;
        i_reg_req = '{w, !w, a, d};
        @(posedge i_clock) #1;
        i_reg_req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rw(1'b0, a, 8'h00);
        chk({8'h00, o_reg_rdata}, {8'h00, e});
        chk({15'h0000, o_reg_rvalid}, 16'h0001);
    endtask
    task automatic per(input logic [7:0] c);
        rw(1'b1, CRC_ADDR_RATE, c);
        chk(16'(o_rate_code), 16'(c));
        i_standby = 0;
        repeat (3) begin
            n = 0;
            do begin
                @(posedge i_clock) #1;
                n++;
            end while (!o_conv_start && n < 16'd9000);
        end
        i_standby = 1;
    endtask
    task automatic pwm(input logic [4:0] f, input logic [5:0] d);
        logic        tk;
        logic [15:0] m;
        i_pwm_cfg = '{f, d};
        repeat (70) begin
            @(posedge i_clock) #1;
            i_pwm_tick = 1'($random(seed));
        end
        n = 0;
        m = 0;
        while (m < exp_hi(f, 6'h3F)) begin
            tk = i_pwm_tick;
            @(posedge i_clock) #1;
            if (tk) begin
                n += 16'(o_pwm_level);
                m++;
            end
            i_pwm_tick = 1'($random(seed));
        end
        chk(n, exp_hi(f, d));
    endtask
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #900us;
        bad_count++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge i_clock);
        #1 i_resetn = 1;
        rd(CRC_ADDR_RATE, CRC_RATE_RESET);
        rd(CRC_ADDR_MAKER_ID, CRC_MAKER_ID_VAL);
        rw(1'b1, CRC_ADDR_DIE_REV, 8'($random(seed)));
        rd(CRC_ADDR_DIE_REV, CRC_DIE_REV_VAL);
        rd(CRC_ADDR_ONESHOT, CRC_READ_ZERO);
        rd(8'h10 + 8'($random(seed) & 63), CRC_READ_ZERO);
        s0 = 16'($random(seed));
        rw(1'b1, CRC_ADDR_RATE, s0[7:0]);
        rd(CRC_ADDR_RATE, s0[7:0]);
        i_resetn = 0;
        repeat (2) @(posedge i_clock);
        #1 i_resetn = 1;
        rd(CRC_ADDR_RATE, CRC_RATE_RESET);
        $display("register test done");
        codes[6] = 8'($random(seed) & 15);
        foreach (codes[k]) begin
            per(codes[k]);
            chk(n, exp_per(codes[k]));
        end
        $display("rate test done");
        for (int k = 0; k < 2; k++) begin
            i_slow = k[0];
            repeat (20) @(posedge i_clock);
            #1 s0 = starts;
            i_reg_req = '{1'b1, 1'b0, CRC_ADDR_ONESHOT, 8'($random(seed))};
            @(posedge i_clock) #1;
            i_reg_req.wdata = 8'($random(seed));
            @(posedge i_clock) #1;
            i_reg_req = '0;
            repeat (40) @(posedge i_clock);
            #1 chk(starts - s0, 16'h0002);
        end
        s0 = starts;
        rw(1'b1, CRC_ADDR_ONESHOT, 8'($random(seed)));
        @(posedge i_clock) #1 chk({14'h0000, o_conv_start, o_conv_busy}, 16'h0003);
        repeat (40) @(posedge i_clock);
        #1 chk({14'h0000, o_conv_start, o_conv_busy}, 16'h0000);
        chk(starts - s0, 16'h0001);
        $display("one-shot test done");
        pwm(5'h00, 6'h01);
        pwm(5'h1F, 6'h3F);
        pwm(5'h02, 6'h00);
        repeat (4) pwm(5'($random(seed)), 6'($random(seed)));
        $display("pwm test done");
        stop_test;
    end
endmodule
